// >>> core/core_map.svh
// Constants for the dual-element core: widths, encodings, field values
`ifndef CORE_MAP_SVH
`define CORE_MAP_SVH
`define DATA_W 40
`define MEM_W 32
`define INSTR_W 48
`define ADDR_W 24
`define NREG 32
`define BANK_REGS 16
`define RD_PORTS 6
`define WR_PORTS 4
`define CACHE_SETS 16
`define CYCLE_NS 10
// Element count: primary plus secondary
`define N_ELEM 2
// ALU operations
`define ALU_NOP 4'h0
`define ALU_ADD 4'h1
`define ALU_SUB 4'h2
`define ALU_AND 4'h3
`define ALU_OR 4'h4
`define ALU_XOR 4'h5
`define ALU_PASS 4'h6
// Multiplier and shifter operations
`define MUL_NOP 2'h0
`define MUL_MUL 2'h1
`define SHF_NOP 2'h0
`define SHF_LSL 2'h1
`define SHF_LSR 2'h2
`define SHF_ASR 2'h3
// Number formats
`define FMT_FIX32 2'h0
`define FMT_FLT32 2'h1
`define FMT_EXT40 2'h2
// Float layout on the 40-bit data word
`define EXP_BIAS 11'h07f
`define EXP_MAX 11'h0ff
`define FLT32_MASK 40'hff_ffff_ff00
`define ZERO_DATA 40'h00_0000_0000
`define ZERO_MEM 32'h0000_0000
`define NOP_INSTR 48'h0000_0000_0000
`endif

// >>> core/core_pkg.sv
// Types shared by the dual-element core and its register file
package core_pkg;
`include "core_map.svh"

   // Decoded 48-bit instruction word
   typedef struct packed {
      logic [3:0] alu_op;
      logic [1:0] mul_op;
      logic [1:0] shf_op;
      logic [1:0] fmt;
      logic [3:0] alu_rd;
      logic [3:0] alu_rx;
      logic [3:0] alu_ry;
      logic [3:0] mul_rd;
      logic [3:0] mul_rx;
      logic [3:0] mul_ry;
      logic [3:0] dm_reg;
      logic dm_en;
      logic dm_wr;
      logic [3:0] pm_reg;
      logic pm_en;
      logic pm_wr;
      logic alt_bank;
      logic spare;
   } instr_t;

   // One bus word per element: x to primary, y to secondary
   typedef struct packed {
      logic [`MEM_W-1:0] x;
      logic [`MEM_W-1:0] y;
   } pair_t;

   typedef enum logic {CACHE_IDLE, CACHE_MISS} cache_state_t;
endpackage

// >>> core/elem_regfile.sv
// Data register file of one processing element: 32 entries, 6 reads, 4 writes
`timescale 1ns/100ps
`include "core_map.svh"
module elem_regfile
   import core_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Element active for this cycle
   input wire logic en,
   // Read ports
   input wire logic [`RD_PORTS-1:0][4:0] rd_idx,
   output logic [`RD_PORTS-1:0][`DATA_W-1:0] rd_data,
   // Write ports, higher port wins on the same index
   input wire logic [`WR_PORTS-1:0] wr_en,
   input wire logic [`WR_PORTS-1:0][4:0] wr_idx,
   input wire logic [`WR_PORTS-1:0][`DATA_W-1:0] wr_data
);

   logic [`DATA_W-1:0] reg_r [`NREG];
   logic [`DATA_W-1:0] reg_nxt [`NREG];

   ////////////////////////////////////////////////////////////////////
   // Combinational reads
   always_comb begin
      for (int p = 0; p < `RD_PORTS; p++) begin
         rd_data[p] = reg_r[rd_idx[p]];
      end
   end

   // Next state; a disabled element keeps every entry
   always_comb begin
      for (int i = 0; i < `NREG; i++) begin
         reg_nxt[i] = reg_r[i];
      end
      if (en) begin
         for (int p = 0; p < `WR_PORTS; p++) begin
            if (wr_en[p]) begin
               reg_nxt[wr_idx[p]] = wr_data[p];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register storage
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < `NREG; i++) begin
            reg_r[i] <= `ZERO_DATA;
         end
      end else begin
         for (int i = 0; i < `NREG; i++) begin
            reg_r[i] <= reg_nxt[i];
         end
      end
   end
endmodule

// >>> core/simd_dual_element_core.sv
// Dual-element SIMD core datapath with selective instruction cache
`timescale 1ns/100ps
`include "core_map.svh"
module simd_dual_element_core
   import core_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Mode control
   input wire logic second_element_enable,
   // Instruction fetch from the sequencer
   input wire logic fetch_valid,
   input wire logic [`ADDR_W-1:0] fetch_addr,
   input wire logic [`INSTR_W-1:0] fetch_word,
   input wire logic pm_data_access,
   output logic fetch_stall,
   output logic cache_hit,
   // Load data from memory, valid in the issue cycle
   input wire pair_t dm_rdata,
   input wire pair_t pm_rdata,
   // Store data and transfer flags, registered
   output pair_t dm_wdata,
   output pair_t pm_wdata,
   output logic dm_read,
   output logic dm_write,
   output logic pm_read,
   output logic pm_write,
   output logic dual_xfer,
   // Status
   output logic issued,
   output logic secondary_active
);

   localparam int CIW = $clog2(`CACHE_SETS);
   localparam int TAGW = `ADDR_W - CIW;

   ////////////////////////////////////////////////////////////////////
   // Arithmetic helpers

   // Register index: bank bit selects the secondary sixteen
   function automatic logic [4:0] ridx(input logic bank, input logic [3:0] r);
      return {bank, r};
   endfunction

   // Lane select of a bus pair for element e
   function automatic logic [`MEM_W-1:0] lane(input pair_t p, input int e);
      return (e == 0) ? p.x : p.y;
   endfunction

   // Renormalise a mantissa whose leading one sits anywhere from bit 0 to bit 32
   function automatic logic [`DATA_W-1:0] f_norm(input logic s,
         input logic signed [10:0] e, input logic [32:0] m);
      logic signed [10:0] ee;
      logic [32:0] mm;
      int lead;
      lead = -1;
      ee = e;
      mm = m;
      for (int i = 0; i < 33; i++) begin
         if (m[i]) begin
            lead = i;
         end
      end
      if (lead < 0) begin
         return `ZERO_DATA;
      end
      if (lead == 32) begin
         mm = m >> 1;
         ee = e + 11'sd1;
      end else begin
         mm = m << (31 - lead);
         ee = e - 11'(31 - lead);
      end
      if (ee <= 11'sd0) begin
         return `ZERO_DATA;
      end
      if (ee >= `EXP_MAX) begin
         return {s, 8'hff, 31'h0000_0000};
      end
      return {s, ee[7:0], mm[30:0]};
   endfunction

   // Float add or subtract on the 40-bit layout, truncating
   function automatic logic [`DATA_W-1:0] f_add(input logic [`DATA_W-1:0] a,
         input logic [`DATA_W-1:0] b, input logic sub);
      logic sa;
      logic sb;
      logic [10:0] ea;
      logic [10:0] eb;
      logic [32:0] ma;
      logic [32:0] mb;
      logic [32:0] t;
      logic [10:0] d;
      sa = a[39];
      sb = b[39] ^ sub;
      ea = {3'h0, a[38:31]};
      eb = {3'h0, b[38:31]};
      ma = (ea == 11'h000) ? 33'h0 : {2'b01, a[30:0]};
      mb = (eb == 11'h000) ? 33'h0 : {2'b01, b[30:0]};
      if (eb > ea) begin
         {sa, sb} = {sb, sa};
         {ea, eb} = {eb, ea};
         t = ma;
         ma = mb;
         mb = t;
      end
      d = ea - eb;
      mb = (d > 11'd32) ? 33'h0 : (mb >> d);
      if (sa == sb) begin
         return f_norm(sa, $signed(ea), ma + mb);
      end else if (ma >= mb) begin
         return f_norm(sa, $signed(ea), ma - mb);
      end
      return f_norm(sb, $signed(ea), mb - ma);
   endfunction

   // Float multiply on the 40-bit layout, truncating
   function automatic logic [`DATA_W-1:0] f_mul(input logic [`DATA_W-1:0] a,
         input logic [`DATA_W-1:0] b);
      logic [63:0] p;
      logic signed [10:0] e;
      if (a[38:31] == 8'h00 || b[38:31] == 8'h00) begin
         return `ZERO_DATA;
      end
      p = {1'b1, a[30:0]} * {1'b1, b[30:0]};
      e = $signed({3'h0, a[38:31]}) + $signed({3'h0, b[38:31]}) - $signed(`EXP_BIAS);
      return f_norm(a[39] ^ b[39], e, p[63:31]);
   endfunction

   // Fit a float result to the selected precision
   function automatic logic [`DATA_W-1:0] f_fit(input logic [1:0] fmt,
         input logic [`DATA_W-1:0] v);
      return (fmt == `FMT_FLT32) ? (v & `FLT32_MASK) : v;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Selective instruction cache
   logic [TAGW-1:0] tag_r [`CACHE_SETS];
   logic [TAGW-1:0] tag_nxt [`CACHE_SETS];
   logic [`INSTR_W-1:0] line_r [`CACHE_SETS];
   logic [`INSTR_W-1:0] line_nxt [`CACHE_SETS];
   logic [`CACHE_SETS-1:0] vld_r;
   logic [`CACHE_SETS-1:0] vld_nxt;
   cache_state_t cst_r;
   cache_state_t cst_nxt;
   logic [`ADDR_W-1:0] miss_r;
   logic [`ADDR_W-1:0] miss_nxt;
   logic [CIW-1:0] cidx;
   logic [TAGW-1:0] ctag;
   logic conflict;
   logic issue_v;
   instr_t ins;

   assign cidx = fetch_addr[CIW-1:0];
   assign ctag = fetch_addr[`ADDR_W-1:CIW];
   assign conflict = fetch_valid & pm_data_access;
   assign cache_hit = conflict & vld_r[cidx] & (tag_r[cidx] == ctag);
   assign fetch_stall = conflict & ~cache_hit;
   // One issue per cycle, from the cache when the program bus carries data
   assign issue_v = fetch_valid & (~conflict | cache_hit);
   assign ins = issue_v ? instr_t'(conflict ? line_r[cidx] : fetch_word) : instr_t'(`NOP_INSTR);

   // Remember a colliding miss and fill it when the refetch comes clean
   always_comb begin
      cst_nxt = cst_r;
      miss_nxt = miss_r;
      vld_nxt = vld_r;
      for (int i = 0; i < `CACHE_SETS; i++) begin
         tag_nxt[i] = tag_r[i];
         line_nxt[i] = line_r[i];
      end
      if (fetch_stall) begin
         cst_nxt = CACHE_MISS;
         miss_nxt = fetch_addr;
      end else begin
         case (cst_r)
            CACHE_IDLE: begin
               cst_nxt = CACHE_IDLE;
            end
            CACHE_MISS: begin
               if (fetch_valid && !conflict && fetch_addr == miss_r) begin
                  vld_nxt[cidx] = 1'b1;
                  tag_nxt[cidx] = ctag;
                  line_nxt[cidx] = fetch_word;
                  cst_nxt = CACHE_IDLE;
               end
            end
            default: begin
               cst_nxt = CACHE_IDLE;
            end
         endcase
      end
   end

   // Cache state registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cst_r <= CACHE_IDLE;
         miss_r <= '0;
         vld_r <= '0;
         for (int i = 0; i < `CACHE_SETS; i++) begin
            tag_r[i] <= '0;
            line_r[i] <= `NOP_INSTR;
         end
      end else begin
         cst_r <= cst_nxt;
         miss_r <= miss_nxt;
         vld_r <= vld_nxt;
         for (int i = 0; i < `CACHE_SETS; i++) begin
            tag_r[i] <= tag_nxt[i];
            line_r[i] <= line_nxt[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Processing elements: same instruction, own register file and lanes
   logic [`N_ELEM-1:0] el_en;
   logic [`N_ELEM-1:0][`RD_PORTS-1:0][4:0] rd_idx;
   logic [`N_ELEM-1:0][`RD_PORTS-1:0][`DATA_W-1:0] rd_dat;
   logic [`N_ELEM-1:0][`WR_PORTS-1:0] wr_en;
   logic [`N_ELEM-1:0][`WR_PORTS-1:0][4:0] wr_idx;
   logic [`N_ELEM-1:0][`WR_PORTS-1:0][`DATA_W-1:0] wr_dat;

   assign el_en[0] = issue_v;
   assign el_en[1] = issue_v & second_element_enable;

   // ALU, multiplier and shifter of each element, all in the issue cycle
   always_comb begin
      logic [`DATA_W-1:0] ax;
      logic [`DATA_W-1:0] ay;
      logic [`DATA_W-1:0] mx;
      logic [`DATA_W-1:0] my;
      logic [`DATA_W-1:0] ar;
      logic [`DATA_W-1:0] mr;
      logic [`MEM_W-1:0] fr;
      logic [63:0] fp;
      logic [5:0] sh;
      logic fl;
      ax = `ZERO_DATA;
      ay = `ZERO_DATA;
      mx = `ZERO_DATA;
      my = `ZERO_DATA;
      ar = `ZERO_DATA;
      mr = `ZERO_DATA;
      fr = `ZERO_MEM;
      fp = '0;
      sh = '0;
      fl = (ins.fmt != `FMT_FIX32);
      for (int e = 0; e < `N_ELEM; e++) begin
         rd_idx[e][0] = ridx(ins.alt_bank, ins.alu_rx);
         rd_idx[e][1] = ridx(ins.alt_bank, ins.alu_ry);
         rd_idx[e][2] = ridx(ins.alt_bank, ins.mul_rx);
         rd_idx[e][3] = ridx(ins.alt_bank, ins.mul_ry);
         rd_idx[e][4] = ridx(ins.alt_bank, ins.dm_reg);
         rd_idx[e][5] = ridx(ins.alt_bank, ins.pm_reg);
         ax = rd_dat[e][0];
         ay = rd_dat[e][1];
         mx = rd_dat[e][2];
         my = rd_dat[e][3];
         sh = ay[13:8];
         // ALU, or shifter when a shift is coded
         case (ins.alu_op)
            `ALU_ADD: ar = fl ? f_fit(ins.fmt, f_add(ax, ay, 1'b0))
                  : {ax[39:8] + ay[39:8], 8'h00};
            `ALU_SUB: ar = fl ? f_fit(ins.fmt, f_add(ax, ay, 1'b1))
                  : {ax[39:8] - ay[39:8], 8'h00};
            `ALU_AND: ar = ax & ay;
            `ALU_OR: ar = ax | ay;
            `ALU_XOR: ar = ax ^ ay;
            `ALU_PASS: ar = ax;
            default: ar = `ZERO_DATA;
         endcase
         case (ins.shf_op)
            `SHF_LSL: fr = ax[39:8] << sh;
            `SHF_LSR: fr = ax[39:8] >> sh;
            `SHF_ASR: fr = $signed(ax[39:8]) >>> sh;
            default: fr = `ZERO_MEM;
         endcase
         if (ins.shf_op != `SHF_NOP) begin
            ar = {fr, 8'h00};
         end
         // Multiplier in parallel with the ALU
         fp = $signed(mx[39:8]) * $signed(my[39:8]);
         mr = fl ? f_fit(ins.fmt, f_mul(mx, my)) : {fp[31:0], 8'h00};
         // Write ports: ALU or shifter, multiplier, data bus, program bus
         wr_en[e][0] = (ins.alu_op != `ALU_NOP) | (ins.shf_op != `SHF_NOP);
         wr_en[e][1] = (ins.mul_op == `MUL_MUL);
         wr_en[e][2] = ins.dm_en & ~ins.dm_wr;
         wr_en[e][3] = ins.pm_en & ~ins.pm_wr;
         wr_idx[e][0] = ridx(ins.alt_bank, ins.alu_rd);
         wr_idx[e][1] = ridx(ins.alt_bank, ins.mul_rd);
         wr_idx[e][2] = ridx(ins.alt_bank, ins.dm_reg);
         wr_idx[e][3] = ridx(ins.alt_bank, ins.pm_reg);
         wr_dat[e][0] = ar;
         wr_dat[e][1] = mr;
         wr_dat[e][2] = {lane(dm_rdata, e), 8'h00};
         wr_dat[e][3] = {lane(pm_rdata, e), 8'h00};
      end
   end

   // One register file per element
   for (genvar g = 0; g < `N_ELEM; g++) begin : g_elem
      elem_regfile u_rf (
         .clk(clk),
         .arst_n(arst_n),
         .en(el_en[g]),
         .rd_idx(rd_idx[g]),
         .rd_data(rd_dat[g]),
         .wr_en(wr_en[g]),
         .wr_idx(wr_idx[g]),
         .wr_data(wr_dat[g])
      );
   end

   ////////////////////////////////////////////////////////////////////
   // Bus transfers: up to four 32-bit words per cycle
   pair_t dmw_r;
   pair_t dmw_nxt;
   pair_t pmw_r;
   pair_t pmw_nxt;
   logic [5:0] fl_r;
   logic [5:0] fl_nxt;

   // Store lanes; the secondary lane moves only in dual mode
   always_comb begin
      dmw_nxt = '0;
      pmw_nxt = '0;
      dmw_nxt.x = rd_dat[0][4][39:8];
      pmw_nxt.x = rd_dat[0][5][39:8];
      if (el_en[1]) begin
         dmw_nxt.y = rd_dat[1][4][39:8];
         pmw_nxt.y = rd_dat[1][5][39:8];
      end
      fl_nxt[0] = issue_v & ins.dm_en & ~ins.dm_wr;
      fl_nxt[1] = issue_v & ins.dm_en & ins.dm_wr;
      fl_nxt[2] = issue_v & ins.pm_en & ~ins.pm_wr;
      fl_nxt[3] = issue_v & ins.pm_en & ins.pm_wr;
      fl_nxt[4] = el_en[1] & (ins.dm_en | ins.pm_en);
      fl_nxt[5] = issue_v;
   end

   // Registered bus outputs
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dmw_r <= '0;
         pmw_r <= '0;
         fl_r <= '0;
      end else begin
         dmw_r <= dmw_nxt;
         pmw_r <= pmw_nxt;
         fl_r <= fl_nxt;
      end
   end

   assign dm_wdata = dmw_r;
   assign pm_wdata = pmw_r;
   assign dm_read = fl_r[0];
   assign dm_write = fl_r[1];
   assign pm_read = fl_r[2];
   assign pm_write = fl_r[3];
   assign dual_xfer = fl_r[4];
   assign issued = fl_r[5];
   assign secondary_active = second_element_enable;
endmodule

// >>> tb/simd_core_properties.sv
// Port checker for the dual-element core, bound to its top module
`timescale 1ns/100ps
module simd_core_properties
   import core_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Mode and fetch
   input wire logic second_element_enable,
   input wire logic fetch_valid,
   input wire logic pm_data_access,
   input wire logic fetch_stall,
   input wire logic cache_hit,
   // Store side
   input wire pair_t dm_wdata,
   input wire pair_t pm_wdata,
   input wire logic dm_read,
   input wire logic dm_write,
   input wire logic pm_read,
   input wire logic pm_write,
   input wire logic dual_xfer,
   // Status
   input wire logic issued,
   input wire logic secondary_active
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   ////////////////////////////////////////////////////////////////////////////////
   // Fetch, cache and issue relations
   a_stall_cause: assert property (fetch_stall |-> fetch_valid && pm_data_access && !cache_hit)
      else $error("stall without a colliding miss");
   a_hit_cause: assert property (cache_hit |-> fetch_valid && pm_data_access)
      else $error("cache hit without a collision");
   a_stall_blocks: assert property (fetch_stall |=> !issued)
      else $error("stalled fetch was issued");
   a_hit_issues: assert property (cache_hit |=> issued)
      else $error("cache hit not issued");
   a_issue_next: assert property (fetch_valid && !fetch_stall |=> issued)
      else $error("accepted fetch not issued");
   a_issue_cause: assert property (issued |-> $past(fetch_valid && !fetch_stall))
      else $error("issue pulse without a fetch");
   a_back_to_back: assert property ((fetch_valid && !fetch_stall) [*2] ##1 1'b1 |-> issued && $past(issued))
      else $error("back to back issue lost");

   ////////////////////////////////////////////////////////////////////////////////
   // Transfer and mode relations
   a_flags_issue: assert property ((dm_read || dm_write || pm_read || pm_write) |-> issued)
      else $error("transfer flag without issue");
   a_dual_flag: assert property ((dm_read || dm_write || pm_read || pm_write) |-> dual_xfer == $past(second_element_enable))
      else $error("dual transfer flag wrong");
   a_dual_only: assert property (dual_xfer |-> dm_read || dm_write || pm_read || pm_write)
      else $error("dual flag without transfer");
   a_single_yzero: assert property (!$past(second_element_enable) |-> (!dm_write || dm_wdata.y == '0) && (!pm_write || pm_wdata.y == '0))
      else $error("secondary lane stored in single mode");
   a_mirror_mode: assert property (secondary_active == second_element_enable)
      else $error("secondary active flag wrong");

   // Main scenarios reached
   c_stall: cover property (fetch_stall);
   c_hit: cover property (cache_hit);
   c_dual_store: cover property (dual_xfer && dm_write && pm_write);
endmodule

bind simd_dual_element_core simd_core_properties chk (.clk(clk), .arst_n(arst_n),
   .second_element_enable(second_element_enable), .fetch_valid(fetch_valid),
   .pm_data_access(pm_data_access), .fetch_stall(fetch_stall), .cache_hit(cache_hit),
   .dm_wdata(dm_wdata), .pm_wdata(pm_wdata), .dm_read(dm_read), .dm_write(dm_write),
   .pm_read(pm_read), .pm_write(pm_write), .dual_xfer(dual_xfer), .issued(issued),
   .secondary_active(secondary_active));

// >>> tb/mem_side_model.sv
// Memory-side model: per-lane load data and a moving idle pattern
`timescale 1ns/100ps
module mem_side_model
   import core_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Load values chosen by the bench
   input wire logic ld_on,
   input wire pair_t dm_v,
   input wire pair_t pm_v,
   // Read data toward the core
   output pair_t dm_rdata,
   output pair_t pm_rdata
);
   logic [31:0] pat_r;
   logic [31:0] pat_nxt;

   // Idle pattern moves every cycle so stale data never looks valid
   always_comb begin
      pat_nxt = pat_r + 32'h0000_0001;
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pat_r <= 32'h5a5a_0000;
      end else begin
         pat_r <= pat_nxt;
      end
   end

   // Both buses hand over both lanes in one cycle
   assign dm_rdata = ld_on ? dm_v : {pat_r, ~pat_r};
   assign pm_rdata = ld_on ? pm_v : {~pat_r, pat_r};
endmodule

// >>> tb/test_simd_dual_element_core.sv
// Self-checking bench for the dual-element core
`timescale 1ns/100ps
`include "core_map.svh"
module test_simd_dual_element_core
   import core_pkg::*;
   ;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic second_element_enable = 1'b0;
   logic fetch_valid = 1'b0;
   logic [`ADDR_W-1:0] fetch_addr = '0;
   logic [`INSTR_W-1:0] fetch_word = '0;
   logic pm_data_access = 1'b0;
   logic ld_on = 1'b0;
   pair_t dm_v = '0;
   pair_t pm_v = '0;
   pair_t dm_rdata, pm_rdata, dm_wdata, pm_wdata;
   logic fetch_stall, cache_hit, dm_read, dm_write, pm_read, pm_write, dual_xfer, issued;
   logic secondary_active;
   int errors = 0;
   int check_count = 0;
   typedef struct packed {
      logic [3:0] op;
      logic [31:0] ax, bx, ay, by, ex, ey;
   } row_t;
   row_t rows [5] = '{
      '{`ALU_ADD, 32'h0000_1234, 32'h0000_0100, 32'h0001_0000, 32'h0000_0002,
        32'h0000_1334, 32'h0001_0002},
      '{`ALU_SUB, 32'h0000_5000, 32'h0000_1000, 32'h0000_0003, 32'h0000_0005,
        32'h0000_4000, 32'hffff_fffe},
      '{`ALU_AND, 32'hf0f0_1234, 32'h0ff0_ff00, 32'haaaa_5555, 32'hffff_0000,
        32'h00f0_1200, 32'haaaa_0000},
      '{`ALU_OR, 32'h1200_0034, 32'h0034_1200, 32'h0000_0000, 32'h8000_0001,
        32'h1234_1234, 32'h8000_0001},
      '{`ALU_XOR, 32'hffff_0000, 32'h0f0f_0f0f, 32'h1234_5678, 32'h1234_5678,
        32'hf0f0_0f0f, 32'h0000_0000}};

   // Clock at 10 MHz
   always #50 clk = ~clk;

   simd_dual_element_core uut (.clk(clk), .arst_n(arst_n),
      .second_element_enable(second_element_enable), .fetch_valid(fetch_valid),
      .fetch_addr(fetch_addr), .fetch_word(fetch_word), .pm_data_access(pm_data_access),
      .fetch_stall(fetch_stall), .cache_hit(cache_hit), .dm_rdata(dm_rdata),
      .pm_rdata(pm_rdata), .dm_wdata(dm_wdata), .pm_wdata(pm_wdata), .dm_read(dm_read),
      .dm_write(dm_write), .pm_read(pm_read), .pm_write(pm_write), .dual_xfer(dual_xfer),
      .issued(issued), .secondary_active(secondary_active));

   mem_side_model mem (.clk(clk), .arst_n(arst_n), .ld_on(ld_on), .dm_v(dm_v), .pm_v(pm_v),
      .dm_rdata(dm_rdata), .pm_rdata(pm_rdata));

   ////////////////////////////////////////////////////////////////////////////////
   // Instruction builders and compare tasks
   function automatic instr_t mv(logic [3:0] d, logic [3:0] p, logic alt, logic wr);
      instr_t i;
      i = `NOP_INSTR;
      i.dm_reg = d;
      i.pm_reg = p;
      i.dm_en = 1'b1;
      i.pm_en = 1'b1;
      i.dm_wr = wr;
      i.pm_wr = wr;
      i.alt_bank = alt;
      return i;
   endfunction

   // ALU r3 = r1 op r2 alongside multiply r4 = r1 * r2
   function automatic instr_t calc(logic [3:0] op, logic [1:0] f);
      instr_t i;
      i = `NOP_INSTR;
      i.alu_op = op;
      i.mul_op = `MUL_MUL;
      i.fmt = f;
      i.alu_rd = 4'h3;
      i.alu_rx = 4'h1;
      i.alu_ry = 4'h2;
      i.mul_rd = 4'h4;
      i.mul_rx = 4'h1;
      i.mul_ry = 4'h2;
      return i;
   endfunction

   task automatic cmp_w(string n, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic cmp_b(string n, logic e, logic g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %b seen %b", n, e, g);
      end
   endtask

   // One instruction, held until the issuing edge
   task automatic exec(instr_t w, pair_t dv, pair_t pv, logic dual);
      @(posedge clk);
      fetch_valid <= 1'b1;
      fetch_word <= w;
      second_element_enable <= dual;
      ld_on <= 1'b1;
      dm_v <= dv;
      pm_v <= pv;
      @(posedge clk);
      fetch_valid <= 1'b0;
      ld_on <= 1'b0;
      #1;
      cmp_b("issued", 1'b1, issued);
   endtask

   // Store on both buses and compare both lanes
   task automatic st_chk(logic [3:0] d, logic [3:0] p, logic alt, logic dual, pair_t ed,
                         pair_t ep);
      exec(mv(d, p, alt, 1'b1), '0, '0, dual);
      cmp_b("dm_write", 1'b1, dm_write);
      cmp_b("pm_write", 1'b1, pm_write);
      cmp_b("dual_xfer", dual, dual_xfer);
      cmp_w("dm_x", ed.x, dm_wdata.x);
      cmp_w("dm_y", ed.y, dm_wdata.y);
      cmp_w("pm_x", ep.x, pm_wdata.x);
      cmp_w("pm_y", ep.y, pm_wdata.y);
   endtask

   // One fetch with or without a program-bus collision
   task automatic fet(logic [`ADDR_W-1:0] a, logic coll, logic es, logic eh);
      @(posedge clk);
      fetch_valid <= 1'b1;
      fetch_addr <= a;
      pm_data_access <= coll;
      fetch_word <= `NOP_INSTR;
      #1;
      cmp_b("fetch_stall", es, fetch_stall);
      cmp_b("cache_hit", eh, cache_hit);
      @(posedge clk);
      fetch_valid <= 1'b0;
      pm_data_access <= 1'b0;
      #1;
      cmp_b("issued", !es, issued);
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [31:0] mx;
      logic [31:0] my;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      // Table: load four operands, compute in both elements, store both lanes
      foreach (rows[k]) begin
         exec(mv(4'h1, 4'h2, 1'b0, 1'b0), {rows[k].ax, rows[k].ay}, {rows[k].bx, rows[k].by}, 1'b1);
         cmp_b("dm_read", 1'b1, dm_read);
         cmp_b("pm_read", 1'b1, pm_read);
         exec(calc(rows[k].op, `FMT_FIX32), '0, '0, 1'b1);
         mx = rows[k].ax * rows[k].bx;
         my = rows[k].ay * rows[k].by;
         st_chk(4'h3, 4'h4, 1'b0, 1'b1, {rows[k].ex, rows[k].ey}, {mx, my});
      end
      // Float case
      exec(mv(4'h1, 4'h2, 1'b0, 1'b0), {32'h3fc0_0000, 32'h3f80_0000},
           {32'h4000_0000, 32'h4000_0000}, 1'b1);
      exec(calc(`ALU_ADD, `FMT_FLT32), '0, '0, 1'b1);
      st_chk(4'h3, 4'h4, 1'b0, 1'b1, {32'h4060_0000, 32'h4040_0000},
             {32'h4040_0000, 32'h4000_0000});
      $display("test table done");
      // Secondary disabled: its registers must not follow single-mode loads
      exec(mv(4'h5, 4'h6, 1'b0, 1'b0), {32'h0000_0011, 32'h0000_00aa},
           {32'h0000_0022, 32'h0000_00bb}, 1'b1);
      exec(mv(4'h5, 4'h6, 1'b0, 1'b0), {32'h0000_0033, 32'h0000_00cc},
           {32'h0000_0044, 32'h0000_00dd}, 1'b0);
      st_chk(4'h5, 4'h6, 1'b0, 1'b0, {32'h0000_0033, 32'h0000_0000},
             {32'h0000_0044, 32'h0000_0000});
      st_chk(4'h5, 4'h6, 1'b0, 1'b1, {32'h0000_0033, 32'h0000_00aa},
             {32'h0000_0044, 32'h0000_00bb});
      $display("test mode done");
      // Alternate bank entries are separate from the primary bank
      exec(mv(4'h7, 4'h8, 1'b1, 1'b0), {32'h0000_0077, 32'h0000_0079},
           {32'h0000_0088, 32'h0000_0089}, 1'b1);
      exec(mv(4'h7, 4'h8, 1'b0, 1'b0), {32'h0000_0017, 32'h0000_0019},
           {32'h0000_0018, 32'h0000_0029}, 1'b1);
      st_chk(4'h7, 4'h8, 1'b1, 1'b1, {32'h0000_0077, 32'h0000_0079},
             {32'h0000_0088, 32'h0000_0089});
      st_chk(4'h7, 4'h8, 1'b0, 1'b1, {32'h0000_0017, 32'h0000_0019},
             {32'h0000_0018, 32'h0000_0029});
      $display("test bank done");
      // Two stores issued on consecutive cycles
      @(posedge clk);
      fetch_valid <= 1'b1;
      fetch_word <= mv(4'h7, 4'h8, 1'b1, 1'b1);
      @(posedge clk);
      fetch_word <= mv(4'h7, 4'h8, 1'b0, 1'b1);
      #1;
      cmp_w("b2b_first", 32'h0000_0077, dm_wdata.x);
      @(posedge clk);
      fetch_valid <= 1'b0;
      #1;
      cmp_b("b2b_issued", 1'b1, issued);
      cmp_w("b2b_second", 32'h0000_0017, dm_wdata.x);
      $display("test back_to_back done");
      // Only colliding fetches are allocated; same set other tag misses
      fet(24'h00_0105, 1'b0, 1'b0, 1'b0);
      fet(24'h00_0105, 1'b1, 1'b1, 1'b0);
      fet(24'h00_0105, 1'b0, 1'b0, 1'b0);
      fet(24'h00_0105, 1'b1, 1'b0, 1'b1);
      fet(24'h00_0115, 1'b1, 1'b1, 1'b0);
      $display("test cache done");
      // Reset in mid-run clears pulses and the cache
      @(posedge clk);
      fetch_valid <= 1'b1;
      fetch_word <= mv(4'h7, 4'h8, 1'b0, 1'b1);
      @(posedge clk);
      fetch_valid <= 1'b0;
      arst_n <= 1'b0;
      #1;
      cmp_b("rst_issued", 1'b0, issued);
      cmp_b("rst_dm_write", 1'b0, dm_write);
      cmp_b("rst_dual", 1'b0, dual_xfer);
      @(posedge clk);
      arst_n <= 1'b1;
      fet(24'h00_0105, 1'b1, 1'b1, 1'b0);
      $display("test reset done");
      close_out();
   end
endmodule
